/* spme_core.sv */
// Serial program/verify mode entry and two-wire exchange, device side.
// Assumes pins arrive asynchronous to clk; data pin split into in/out/oe.
`timescale 1ns/10ps
module spme_core (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Programming pin and oscillator
   input  wire logic                         high_entry_level,
   input  wire logic                         oscillator_input_pin,
   input  wire logic [1:0]                   osc_select,
   input  wire logic                         code_protect,
   // Serial pins
   input  wire logic                         port_b_bit_six,
   input  wire logic                         port_b_bit_seven_in,
   output      logic                         port_b_bit_seven_out,
   output      logic                         port_b_bit_seven_oe_n,
   // Core side
   input  wire logic                         watchdog_timer_expired,
   output      logic                         watchdog_reset,
   output      logic                         prog_mode,
   output      logic                         run_enable,
   output      logic [spme_pkg::PC_W-1:0]    program_counter
);
   import spme_pkg::*;

   // Two-flop synchronisers
   logic [1:0] vpp_s_q, clk_s_q, dat_s_q, osc_s_q;
   logic       sclk_prev_q, osc_prev_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         vpp_s_q     <= 2'h0;
         clk_s_q     <= 2'h0;
         dat_s_q     <= 2'h0;
         osc_s_q     <= 2'h0;
         sclk_prev_q <= 1'b0;
         osc_prev_q  <= 1'b0;
      end else begin
         vpp_s_q     <= {vpp_s_q[0], high_entry_level};
         clk_s_q     <= {clk_s_q[0], port_b_bit_six};
         dat_s_q     <= {dat_s_q[0], port_b_bit_seven_in};
         osc_s_q     <= {osc_s_q[0], oscillator_input_pin};
         sclk_prev_q <= clk_s_q[1];
         osc_prev_q  <= osc_s_q[1];
      end
   end

   logic vpp, sclk, sdat, sclk_fall, osc_edge;
   assign vpp       = vpp_s_q[1];
   assign sclk      = clk_s_q[1];
   assign sdat      = dat_s_q[1];
   assign sclk_fall = sclk_prev_q & ~sclk;
   assign osc_edge  = osc_prev_q ^ osc_s_q[1];

   // Mode, start-up and counter state
   spme_state_t       state_q, state_d;
   logic              mode_q, mode_d;
   logic [10:0]       ost_q, ost_d;
   logic [2:0]        tog_q, tog_d;
   logic [PC_W-1:0]   pc_q, pc_d;
   logic [4:0]        bit_q, bit_d;
   logic [CMD_W-1:0]  cmd_q, cmd_d;
   logic [DATA_W-1:0] sh_q, sh_d;
   logic              drv_q, drv_d;
   logic              wr_d, wr_q;
   logic [DATA_W-1:0] mem_rd;

   function automatic logic is_read(input logic [CMD_W-1:0] c);
      return (c == CMD_READ) || (c == CMD_READ_ID);
   endfunction

   logic ost_done;
   // Crystal waits out the start-up count; RC and external start at once
   assign ost_done = (osc_select != OSC_CRYSTAL) || (ost_q == 11'(OST_CYCLES));

   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      ost_d   = ost_q;
      tog_d   = tog_q;
      pc_d    = pc_q;
      bit_d   = bit_q;
      cmd_d   = cmd_q;
      sh_d    = sh_q;
      drv_d   = drv_q;
      wr_d    = 1'b0;
      if (!mode_q) begin
         state_d = SPME_IDLE;
         drv_d   = 1'b0;
         if (osc_edge && (osc_select == OSC_CRYSTAL) && !ost_done) begin
            ost_d = ost_q + 11'h001;
         end
         // Early oscillator toggles advance the counter when no start-up timer runs
         if (osc_edge && ost_done) begin
            if (tog_q != 3'(EARLY_TOGGLES)) begin
               tog_d = tog_q + 3'h1;
            end
            // Fourth and later edges already move the counter
            if (tog_q >= 3'(EARLY_TOGGLES-1)) begin
               pc_d = pc_q + 21'h000001;
            end
         end
         // Entry sampled only with both serial lines low
         if (vpp && !sclk && !sdat) begin
            mode_d  = 1'b1;
            state_d = SPME_CMD;
            bit_d   = 5'h00;
         end
      end else if (!vpp) begin
         mode_d  = 1'b0;
         state_d = SPME_IDLE;
         drv_d   = 1'b0;
         pc_d    = PC_RESET;
         tog_d   = 3'h0;
         ost_d   = 11'h000;
      end else begin
         case (state_q)
            SPME_CMD: begin
               if (sclk_fall) begin
                  cmd_d = {sdat, cmd_q[CMD_W-1:1]};
                  bit_d = bit_q + 5'h01;
                  if (bit_q == 5'(CMD_W-1)) begin
                     bit_d   = 5'h00;
                     state_d = SPME_EXEC;
                  end
               end
            end
            SPME_EXEC: begin
               cmd_d   = cmd_q;
               state_d = SPME_CMD;
               if (cmd_q == CMD_LOAD) begin
                  state_d = SPME_LOAD;
               end else if (cmd_q == CMD_INC_ADDR) begin
                  pc_d = pc_q + 21'h000001;
               end else if (is_read(cmd_q)) begin
                  // Protected memory reads as zero; ID stays visible
                  sh_d    = code_protect ? 16'h0000 : mem_rd;
                  if (cmd_q == CMD_READ_ID) begin
                     sh_d = {DEVNUM_VALUE, REV_VALUE};
                  end
                  drv_d   = 1'b1;
                  state_d = SPME_READ;
               end
            end
            SPME_LOAD: begin
               if (sclk_fall) begin
                  sh_d  = {sdat, sh_q[DATA_W-1:1]};
                  bit_d = bit_q + 5'h01;
                  if (bit_q == 5'(DATA_W-1)) begin
                     bit_d   = 5'h00;
                     wr_d    = ~code_protect;
                     state_d = SPME_CMD;
                  end
               end
            end
            SPME_READ: begin
               if (sclk_fall) begin
                  sh_d  = {1'b0, sh_q[DATA_W-1:1]};
                  bit_d = bit_q + 5'h01;
                  if (bit_q == 5'(DATA_W-1)) begin
                     bit_d   = 5'h00;
                     drv_d   = 1'b0;
                     state_d = SPME_CMD;
                  end
               end
            end
            default: state_d = SPME_CMD;
         endcase
      end
      // An early-advanced counter is kept on entry
      if (!mode_q && mode_d && (tog_d != 3'(EARLY_TOGGLES))) begin
         pc_d = PC_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= SPME_IDLE;
         mode_q  <= 1'b0;
         ost_q   <= 11'h000;
         tog_q   <= 3'h0;
         pc_q    <= PC_RESET;
         bit_q   <= 5'h00;
         cmd_q   <= 6'h00;
         sh_q    <= 16'h0000;
         drv_q   <= 1'b0;
         wr_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         ost_q   <= ost_d;
         tog_q   <= tog_d;
         pc_q    <= pc_d;
         bit_q   <= bit_d;
         cmd_q   <= cmd_d;
         sh_q    <= sh_d;
         drv_q   <= drv_d;
         wr_q    <= wr_d;
      end
   end

   spme_mem u_mem (
      .clk     (clk),
      .wr_en   (wr_q),
      .addr    (pc_q[MEM_AW-1:0]),
      .wr_data (sh_q),
      .rd_data (mem_rd)
   );

   assign port_b_bit_seven_out  = sh_q[0];
   assign port_b_bit_seven_oe_n = ~drv_q;
   assign watchdog_reset        = watchdog_timer_expired & ~mode_q;
   assign prog_mode             = mode_q;
   assign run_enable            = ~mode_q & ost_done;
   assign program_counter       = pc_q;
endmodule

/* spme_pkg.sv */
// Package for the serial program/verify mode entry block.
// Assumes a 50 MHz core clock and a slow serial clock from the programmer.
package spme_pkg;
   localparam int          PC_W            = 21;
   localparam logic [20:0] PC_RESET        = 21'h000000;
   localparam int          CMD_W           = 6;
   localparam int          DATA_W          = 16;
   localparam int          REV_W           = 5;
   localparam int          DEVNUM_W        = 11;
   // Identity values are arbitrary
   localparam logic [4:0]  REV_VALUE       = 5'h01;
   localparam logic [10:0] DEVNUM_VALUE    = 11'h123;
   localparam int          OST_CYCLES      = 1024;
   localparam int          EARLY_TOGGLES   = 4;
   localparam int          MEM_AW          = 6;
   // Command codes and oscillator selections
   localparam logic [5:0]  CMD_LOAD        = 6'h02;
   localparam logic [5:0]  CMD_READ        = 6'h04;
   localparam logic [5:0]  CMD_INC_ADDR    = 6'h06;
   localparam logic [5:0]  CMD_READ_ID     = 6'h08;
   localparam logic [1:0]  OSC_CRYSTAL     = 2'h0;
   localparam logic [1:0]  OSC_RC          = 2'h1;
   localparam logic [1:0]  OSC_EXT         = 2'h2;
   typedef enum logic [2:0] {SPME_IDLE, SPME_CMD, SPME_LOAD, SPME_READ, SPME_EXEC} spme_state_t;
endpackage

/* spme_mem.sv */
// Small program word store for the program/verify path.
// Assumes one write or one read per cycle; read data is registered.
`timescale 1ns/10ps
module spme_mem (
   // Clock
   input  wire logic                         clk,
   // Access
   input  wire logic                         wr_en,
   input  wire logic [spme_pkg::MEM_AW-1:0]  addr,
   input  wire logic [spme_pkg::DATA_W-1:0]  wr_data,
   output      logic [spme_pkg::DATA_W-1:0]  rd_data
);
   import spme_pkg::*;
   logic [DATA_W-1:0] store [0:(1<<MEM_AW)-1];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[addr] <= wr_data;
      end
      rd_data <= store[addr];
   end
endmodule

/* spme_core_monitor.sv */
// Checker for the program/verify entry block.
// Bound to spme_core; sees only its ports.
`timescale 1ns/10ps
module spme_core_monitor (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // Pins
   input wire logic                      high_entry_level,
   input wire logic [1:0]                osc_select,
   input wire logic                      port_b_bit_six,
   input wire logic                      port_b_bit_seven_in,
   input wire logic                      port_b_bit_seven_oe_n,
   // Core side
   input wire logic                      watchdog_reset,
   input wire logic                      prog_mode,
   input wire logic                      run_enable,
   input wire logic [spme_pkg::PC_W-1:0] program_counter
);
   import spme_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Two sync flops plus the mode register: the cause shows three cycles back
   a_entry_cause: assert property ($rose(prog_mode) |-> $past(high_entry_level, 3) &&
      !$past(port_b_bit_six, 3) && !$past(port_b_bit_seven_in, 3)) else $error("entry without cause");
   a_wdt_blocked: assert property (prog_mode |-> !watchdog_reset)
      else $error("watchdog reset in mode");
   a_no_run_mode: assert property (prog_mode |-> !run_enable)
      else $error("run enabled in mode");
   a_data_idle: assert property (!prog_mode |-> port_b_bit_seven_oe_n)
      else $error("data driven outside mode");
   a_data_hold: assert property ($fell(port_b_bit_seven_oe_n) |-> !port_b_bit_seven_oe_n [*8])
      else $error("read drive too short");
   a_leave_mode: assert property ($fell(high_entry_level) |-> ##[1:4] !prog_mode)
      else $error("mode not left");
   a_leave_pc: assert property ($fell(prog_mode) |-> ##[0:2] (program_counter == '0))
      else $error("counter not cleared");
   a_rc_run: assert property (!prog_mode && osc_select != OSC_CRYSTAL |=> run_enable || prog_mode)
      else $error("start-up delay applied");
   c_entry: cover property ($rose(prog_mode));
   c_read: cover property ($fell(port_b_bit_seven_oe_n));
   c_xtal: cover property ($rose(run_enable) && osc_select == OSC_CRYSTAL);
endmodule
bind spme_core spme_core_monitor mon (.*);

/* spme_prog_model.sv */
// Programmer model: serial clock and data line.
// Tasks are entered and return just after a clock edge.
`timescale 1ns/10ps
module spme_prog_model (
   // Clock
   input wire logic clk,
   // Device data pin
   input wire logic dev_out,
   input wire logic dev_oe_n,
   // Lines to the device
   output     logic sclk,
   output     logic line
);
   logic drv, val, last;
   initial begin
      sclk = 1'b0;
      drv = 1'b1;
      val = 1'b0;
      last = 1'b0;
   end
   // Released line flips each cycle, never a stale value
   always_comb line = !dev_oe_n ? dev_out : drv ? val : ~last;
   always @(posedge clk) last <= line;
   task automatic send(input logic [21:0] v, input int n);
      drv = 1'b1;
      for (int i = 0; i < n; i++) begin
         val = v[i];
         sclk = 1'b1;
         repeat (4) @(posedge clk);
         #1 sclk = 1'b0;
         repeat (4) @(posedge clk);
         #1;
      end
   endtask
   task automatic recv(output logic [15:0] r);
      drv = 1'b0;
      for (int i = 0; i < 16; i++) begin
         sclk = 1'b1;
         repeat (4) @(posedge clk);
         #1 r[i] = line;
         sclk = 1'b0;
         repeat (4) @(posedge clk);
         #1;
      end
      drv = 1'b1;
      val = 1'b0;
   endtask
endmodule

/* spme_core_bench.sv */
// Bench for the program/verify entry block.
// Pins driven here; the model supplies serial clock and data.
`timescale 1ns/10ps
module spme_core_bench;
   import spme_pkg::*;
   logic            clk, rst, hel, osc, cp, wdx, sclk, line, dout, oe_n, wdr, pm, run;
   logic [1:0]      sel;
   logic [PC_W-1:0] pc;
   logic [15:0]     rd;
   int              failures, total_checks;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   spme_core dut (.clk(clk), .rst(rst), .high_entry_level(hel), .oscillator_input_pin(osc),
      .osc_select(sel), .code_protect(cp), .port_b_bit_six(sclk), .port_b_bit_seven_in(line),
      .port_b_bit_seven_out(dout), .port_b_bit_seven_oe_n(oe_n), .watchdog_timer_expired(wdx),
      .watchdog_reset(wdr), .prog_mode(pm), .run_enable(run), .program_counter(pc));
   spme_prog_model prog (.clk(clk), .dev_out(dout), .dev_oe_n(oe_n), .sclk(sclk), .line(line));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic set_mode(input logic v);
      int n;
      hel = v;
      for (n = 0; n < 40 && pm !== v; n++)
         step(1);
      if (n == 40) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic toggle(input int n);
      repeat (n) begin
         osc = ~osc;
         step(4);
      end
   endtask
   task automatic reset_to(input logic [1:0] s);
      rst = 1'b1;
      hel = 1'b0;
      sel = s;
      osc = 1'b0;
      step(3);
      rst = 1'b0;
      step(3);
   endtask
   task automatic t_program();
      reset_to(OSC_RC);
      set_mode(1'b1); // Oscillator held still
      check(pc, 0);
      wdx = 1'b1;
      step(1);
      check(wdr, 0);
      prog.send({16'ha5c3, CMD_LOAD}, 22);
      prog.send(CMD_READ, 6);
      check(oe_n, 0);
      prog.recv(rd);
      check(rd, 16'ha5c3);
      check(oe_n, 1);
      prog.send(6'h3f, 6);
      prog.send(CMD_INC_ADDR, 6);
      step(6);
      check(pc, 1);
      cp = 1'b1;
      prog.send(CMD_READ_ID, 6);
      prog.recv(rd);
      check(rd, {DEVNUM_VALUE, REV_VALUE});
      prog.send(CMD_READ, 6);
      prog.recv(rd);
      check(rd, 16'h0000);
      set_mode(1'b0);
      check(pc, 0);
      check(wdr, 1);
   endtask
   task automatic t_early();
      reset_to(OSC_RC);
      check(run, 1);
      toggle(4);
      set_mode(1'b1);
      check(pc != 0, 1);
   endtask
   task automatic t_quick_entry();
      reset_to(OSC_EXT);
      check(run, 1);
      toggle(3);
      set_mode(1'b1); // Entry before the fourth toggle
      check(pc, 0);
   endtask
   task automatic t_crystal();
      reset_to(OSC_CRYSTAL);
      toggle(1023);
      check(run, 0);
      toggle(1);
      check(run, 1);
   endtask
   initial begin
      rst = 1'b1;
      hel = 1'b0;
      osc = 1'b0;
      cp = 1'b0;
      wdx = 1'b0;
      sel = OSC_RC;
      failures = 0;
      total_checks = 0;
      #1;
      t_program();
      t_early();
      t_quick_entry();
      t_crystal();
      end_sim();
   end
endmodule
